// File: vtp_pkg.sv
// vtp_pkg: shared constants, types and decode functions of the pixel path
// assumes a single 250 MHz clock domain; host owns all configuration inputs

package vtp_pkg;

   // ************************************************************
   // clock and widths
   // ************************************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PAL_DEPTH = 256;
   localparam int XFER_ADDR_W = 24;
   localparam int STEP_W = 13;

   // ************************************************************
   // pixel depth encodings and transfer steps
   // ************************************************************
   typedef enum logic [1:0] {
      VTP_BPP1 = 2'b00,
      VTP_BPP2 = 2'b01,
      VTP_BPP4 = 2'b10,
      VTP_BPP8 = 2'b11
   } vtp_depth_e;

   localparam logic [STEP_W-1:0] STEP_256 = 13'h0100;
   localparam logic [STEP_W-1:0] STEP_512 = 13'h0200;
   localparam logic [STEP_W-1:0] STEP_1024 = 13'h0400;
   localparam logic [STEP_W-1:0] STEP_2048 = 13'h0800;
   localparam logic [STEP_W-1:0] STEP_4096 = 13'h1000;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [STEP_W-1:0] STEP_RST = STEP_256;
   localparam logic [XFER_ADDR_W-1:0] XFER_ADDR_RST = 24'h000000;
   localparam logic [3:0] CNT_RST = 4'h0;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } vtp_rgb_s;

   // ************************************************************
   // decode functions
   // ************************************************************
   // palette index mask: only the low 2^n entries are reachable
   function automatic logic [7:0] vtp_mask(input vtp_depth_e d);
      case (d)
         VTP_BPP1: vtp_mask = 8'h01;
         VTP_BPP2: vtp_mask = 8'h03;
         VTP_BPP4: vtp_mask = 8'h0F;
         default: vtp_mask = 8'hFF;
      endcase
   endfunction

   // pixels packed in one frame byte
   function automatic logic [3:0] vtp_ppb(input vtp_depth_e d);
      case (d)
         VTP_BPP1: vtp_ppb = 4'h8;
         VTP_BPP2: vtp_ppb = 4'h4;
         VTP_BPP4: vtp_ppb = 4'h2;
         default: vtp_ppb = 4'h1;
      endcase
   endfunction

   // bits consumed per pixel
   function automatic logic [3:0] vtp_bits(input vtp_depth_e d);
      case (d)
         VTP_BPP1: vtp_bits = 4'h1;
         VTP_BPP2: vtp_bits = 4'h2;
         VTP_BPP4: vtp_bits = 4'h4;
         default: vtp_bits = 4'h8;
      endcase
   endfunction

   // interlace doubles the step so both fields share one framestore layout
   function automatic logic [STEP_W-1:0] vtp_step(input logic ilace, input logic [1:0] sel);
      case ({ilace, sel})
         3'h0: vtp_step = STEP_256;
         3'h1: vtp_step = STEP_512;
         3'h2: vtp_step = STEP_1024;
         3'h3: vtp_step = STEP_2048;
         3'h4: vtp_step = STEP_512;
         3'h5: vtp_step = STEP_1024;
         3'h6: vtp_step = STEP_2048;
         default: vtp_step = STEP_4096;
      endcase
   endfunction

endpackage

// File: vtp_skid2.sv
// vtp_skid2: two-entry buffer (output register plus skid register)
// assumes one clock; in_ready_out comes from a flop, outputs come from flops

`timescale 1ns/1ps

module vtp_skid2 #(
   parameter int WIDTH = 24
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);

   logic [WIDTH-1:0] skid;
   logic skid_valid;
   wire take_out = out_ready_in || !out_valid_out;
   wire push = in_valid_in && in_ready_out;

   // ************************************************************
   // storage
   // ************************************************************
   // a stalled receiver parks one word in the skid slot, so none is lost
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         out_valid_out <= 1'b0;
         skid_valid <= 1'b0;
      end else if (take_out) begin
         out_valid_out <= skid_valid || push;
         skid_valid <= 1'b0;
      end else if (push) begin
         skid_valid <= 1'b1;
      end
   end

   // data paths carry no reset
   always_ff @(posedge ref_clk_in) begin
      if (take_out && skid_valid) begin
         out_data_out <= skid;
      end else if (take_out && push) begin
         out_data_out <= in_data_in;
      end
      if (!take_out && push) begin
         skid <= in_data_in;
      end
   end

   assign in_ready_out = !skid_valid;

endmodule

// File: vtp_pixel_path.sv
// vtp_pixel_path: frame-memory unpacking, palette lookup, transfer stepping
// and composite blank pin of a video timing generator's pixel path
// assumes host configuration inputs and the palette port are same-clock;
// the composite blank pin is asynchronous

`timescale 1ns/1ps

module vtp_pixel_path (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic timing_enable_in,
   input wire logic full_colour_in,
   input wire logic interlace_in,
   input wire logic [1:0] pixel_depth_in,
   input wire logic [1:0] addr_step_sel_in,
   input wire logic blank_drive_in,
   input wire logic local_blank_in,
   input wire logic pal_wr_en_in,
   input wire logic [7:0] pal_wr_addr_in,
   input wire vtp_pkg::vtp_rgb_s pal_wr_data_in,
   input wire logic vram_valid_in,
   input wire logic [23:0] vram_data_in,
   output logic vram_ready_out,
   input wire logic frame_start_in,
   input wire logic xfer_req_in,
   output logic [vtp_pkg::XFER_ADDR_W-1:0] xfer_addr_out,
   output logic [vtp_pkg::STEP_W-1:0] xfer_step_out,
   input wire logic blank_pin_in,
   output logic blank_pin_out,
   output logic blank_pin_oe_n_out,
   output logic blank_active_out,
   output logic pix_valid_out,
   input wire logic pix_ready_in,
   output vtp_pkg::vtp_rgb_s pix_rgb_out
);

   // ************************************************************
   // declarations
   // ************************************************************
   typedef enum logic [0:0] {
      VTP_IDLE = 1'b0,
      VTP_UNPACK = 1'b1
   } vtp_state_e;

   vtp_state_e state;
   vtp_state_e next_state;
   vtp_pkg::vtp_rgb_s palette [vtp_pkg::PAL_DEPTH];
   logic [23:0] word;
   logic [3:0] cnt_left;
   logic buf_ready;
   logic [2:0] blank_sync;
   logic ext_blank;

   // ************************************************************
   // configuration decode
   // ************************************************************
   wire vtp_pkg::vtp_depth_e depth = vtp_pkg::vtp_depth_e'(pixel_depth_in);
   wire [7:0] depth_mask = vtp_pkg::vtp_mask(depth);
   wire [3:0] depth_bits = vtp_pkg::vtp_bits(depth);
   wire [3:0] depth_ppb = full_colour_in ? 4'h1 : vtp_pkg::vtp_ppb(depth);
   wire [vtp_pkg::STEP_W-1:0] step_sel = vtp_pkg::vtp_step(interlace_in, addr_step_sel_in);

   // ************************************************************
   // unpacking control
   // ************************************************************
   // a word is taken only on valid with ready, so the source never hands it over twice
   wire accept = timing_enable_in && vram_ready_out && (state == VTP_IDLE) && vram_valid_in;
   wire emit = timing_enable_in && (state == VTP_UNPACK) && buf_ready;
   wire last = (cnt_left == 4'h1);
   wire [7:0] cur_index = word[7:0] & depth_mask;

   // disabling the generator drops any half-used word
   always_comb begin
      next_state = state;
      case (state)
         VTP_IDLE: begin
            if (accept) begin
               next_state = VTP_UNPACK;
            end
         end
         VTP_UNPACK: begin
            if (!timing_enable_in || (emit && last)) begin
               next_state = VTP_IDLE;
            end
         end
         default: next_state = VTP_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= VTP_IDLE;
         cnt_left <= vtp_pkg::CNT_RST;
      end else begin
         state <= next_state;
         if (accept) begin
            cnt_left <= depth_ppb;
         end else if (emit) begin
            cnt_left <= cnt_left - 4'h1;
         end
      end
   end

   // earliest pixel sits in the lowest bits, so shift right after each
   always_ff @(posedge ref_clk_in) begin
      if (accept) begin
         word <= vram_data_in;
      end else if (emit) begin
         word <= word >> depth_bits;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vram_ready_out <= 1'b0;
      end else begin
         vram_ready_out <= timing_enable_in && (next_state == VTP_IDLE);
      end
   end

   // ************************************************************
   // palette
   // ************************************************************
   // flop storage; host writes only while no pixels are shown
   always_ff @(posedge ref_clk_in) begin
      if (pal_wr_en_in) begin
         palette[pal_wr_addr_in] <= pal_wr_data_in;
      end
   end

   // full colour: three independent lookups, one per colour field
   wire vtp_pkg::vtp_rgb_s pseudo_rgb = palette[cur_index];
   wire vtp_pkg::vtp_rgb_s full_rgb = {palette[word[23:16]].red, palette[word[15:8]].green,
      palette[word[7:0]].blue};
   wire vtp_pkg::vtp_rgb_s lookup_rgb = full_colour_in ? full_rgb : pseudo_rgb;

   // ************************************************************
   // output buffer
   // ************************************************************
   vtp_skid2 #(
      .WIDTH(24)
   ) u_buf (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .in_valid_in(emit),
      .in_data_in(lookup_rgb),
      .in_ready_out(buf_ready),
      .out_valid_out(pix_valid_out),
      .out_ready_in(pix_ready_in),
      .out_data_out(pix_rgb_out)
   );

   // ************************************************************
   // transfer address stepping
   // ************************************************************
   // step is registered so a mid-line change cannot glitch the sum
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         xfer_step_out <= vtp_pkg::STEP_RST;
         xfer_addr_out <= vtp_pkg::XFER_ADDR_RST;
      end else begin
         xfer_step_out <= step_sel;
         if (frame_start_in) begin
            xfer_addr_out <= vtp_pkg::XFER_ADDR_RST;
         end else if (xfer_req_in) begin
            xfer_addr_out <= xfer_addr_out + {11'h000, xfer_step_out};
         end
      end
   end

   // ************************************************************
   // composite blank pin
   // ************************************************************
   // three-flop synchroniser; level changes only when stages 2 and 3 agree
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         blank_sync <= 3'h0;
         ext_blank <= 1'b0;
      end else begin
         blank_sync <= {blank_sync[1:0], blank_pin_in};
         if (blank_sync[1] == blank_sync[2]) begin
            ext_blank <= blank_sync[2];
         end
      end
   end

   // output enable is active low; input mode lets another device blank us
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         blank_pin_oe_n_out <= 1'b1;
         blank_pin_out <= 1'b0;
         blank_active_out <= 1'b0;
      end else begin
         blank_pin_oe_n_out <= !blank_drive_in;
         blank_pin_out <= local_blank_in;
         blank_active_out <= blank_drive_in ? local_blank_in : ext_blank;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   sequence take_word;
      accept;
   endsequence

   depth_count_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      take_word |=> cnt_left == (($past(full_colour_in)) ? 4'h1
         : vtp_pkg::vtp_ppb(vtp_pkg::vtp_depth_e'($past(pixel_depth_in)))))
      else $error("pixel count per byte does not follow depth");

   index_range_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (emit && !full_colour_in && pixel_depth_in == 2'b10) |-> cur_index <= 8'h0F)
      else $error("4-bit pixel index above 15");

   first_pixel_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      take_word ##1 (pixel_depth_in == 2'b00) |->
         cur_index == {7'h00, $past(vram_data_in[0])})
      else $error("earliest pixel not from lowest bit");

   step_sel_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      interlace_in && addr_step_sel_in == 2'b01 |=> xfer_step_out == 13'h0400)
      else $error("interlaced step not doubled");

   step_base_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (!interlace_in && addr_step_sel_in == 2'b00) ##1 xfer_req_in && !frame_start_in
         |=> xfer_addr_out == $past(xfer_addr_out) + 24'h000100)
      else $error("base step is not 256");

   blank_dir_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      blank_drive_in |=> !blank_pin_oe_n_out && blank_active_out == $past(local_blank_in))
      else $error("blank pin not driven in output mode");

   full_lookup_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      (emit && full_colour_in) |-> lookup_rgb.green == palette[word[15:8]].green
         && lookup_rgb.red == palette[word[23:16]].red)
      else $error("full colour field used wrong palette address");

   disable_flush_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
      !timing_enable_in |=> state == VTP_IDLE && !vram_ready_out)
      else $error("disabled generator still unpacking");

endmodule

// File: vtp_vram_model.sv
// vtp_vram_model: frame memory source that offers one word at a time
// assumes the pixel path takes a word at an edge where valid and ready are high
`timescale 1ns/1ps

// ************************************************************
// frame memory source
// ************************************************************
module vtp_vram_model (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic send_in,
   input wire logic slow_in,
   input wire logic [23:0] word_in,
   input wire logic vram_ready_in,
   output logic vram_valid_out,
   output logic [23:0] vram_data_out,
   output logic busy_out
);
   logic [23:0] hold;
   logic [1:0] cnt;

   // word held until taken; released data flips so stale bytes never match
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vram_valid_out <= 1'b0;
         vram_data_out <= 24'h000000;
         busy_out <= 1'b0;
         hold <= 24'h000000;
         cnt <= 2'h0;
      end else if (vram_valid_out && vram_ready_in) begin
         vram_valid_out <= 1'b0;
         vram_data_out <= ~vram_data_out;
         busy_out <= 1'b0;
      end else if (send_in && !busy_out) begin
         busy_out <= 1'b1;
         hold <= word_in;
         cnt <= slow_in ? 2'h3 : 2'h0; // slow answer waits three cycles
      end else if (busy_out && !vram_valid_out) begin
         if (cnt == 2'h0) begin
            vram_valid_out <= 1'b1;
            vram_data_out <= hold;
         end else begin
            cnt <= cnt - 2'h1;
         end
      end
   end
endmodule

// File: testbench.sv
// testbench: self-checking bench of the pixel path with a frame memory model
// assumes a 250 MHz clock; inputs change 1 ns after each rising edge
`timescale 1ns/1ps

module testbench;
   // ************************************************************
   // signals
   // ************************************************************
   logic ref_clk_in, arst_n_in, en, fc, ilace, bdrv, lblank, ext_blank;
   logic pwe, fs, xr, send, slow, pix_ready, vvalid, vready, busy;
   logic pvalid, oe_n, bpin_out, bact;
   logic [1:0] depth, ssel, stall_mode;
   logic [7:0] pwa;
   logic [23:0] word, vdata, xaddr;
   logic [12:0] xstep;
   vtp_pkg::vtp_rgb_s pwd, prgb;
   vtp_pkg::vtp_rgb_s pal_m [256];
   vtp_pkg::vtp_rgb_s exp_q [$];
   wire pin_level = oe_n ? ext_blank : bpin_out; // shared blank wire
   integer num_errors, n_tests, seed, cyc, i, k, n_pix;

   vtp_pixel_path vtp_pixel_path_i (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .timing_enable_in(en), .full_colour_in(fc), .interlace_in(ilace),
      .pixel_depth_in(depth), .addr_step_sel_in(ssel), .blank_drive_in(bdrv),
      .local_blank_in(lblank), .pal_wr_en_in(pwe), .pal_wr_addr_in(pwa),
      .pal_wr_data_in(pwd), .vram_valid_in(vvalid), .vram_data_in(vdata),
      .vram_ready_out(vready), .frame_start_in(fs), .xfer_req_in(xr),
      .xfer_addr_out(xaddr), .xfer_step_out(xstep), .blank_pin_in(pin_level),
      .blank_pin_out(bpin_out), .blank_pin_oe_n_out(oe_n), .blank_active_out(bact),
      .pix_valid_out(pvalid), .pix_ready_in(pix_ready), .pix_rgb_out(prgb));
   vtp_vram_model vtp_vram_model_i (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .send_in(send), .slow_in(slow), .word_in(word), .vram_ready_in(vready),
      .vram_valid_out(vvalid), .vram_data_out(vdata), .busy_out(busy));

   // ************************************************************
   // clock, timeout, pixel receiver
   // ************************************************************
   initial begin
      ref_clk_in = 1'b0;
      forever #2 ref_clk_in = ~ref_clk_in;
   end
   // ceiling sized well above the little over a thousand cycles the tests need
   always @(posedge ref_clk_in) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         num_errors = num_errors + 1;
         give_verdict();
      end
   end
   // receiver stalls at random or holds off to fill the buffer
   always @(posedge ref_clk_in) begin
      if (pvalid === 1'b1 && pix_ready === 1'b1) begin
         n_pix = n_pix + 1;
         if (exp_q.size() == 0) check_val(24'hFFFFFF, 24'h000000);
         else check_rgb(prgb, exp_q.pop_front());
      end
      #1 pix_ready = (stall_mode == 2'h0) ? 1'b1 :
         (stall_mode == 2'h1) ? 1'($random(seed)) : 1'b0;
   end

   // ************************************************************
   // compare and stimulus tasks
   // ************************************************************
   task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_rgb(input vtp_pkg::vtp_rgb_s got, input vtp_pkg::vtp_rgb_s exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   // expected transfer step, worked out from the step table
   function automatic logic [23:0] exp_step(input logic il, input logic [1:0] s);
      exp_step = 24'h000100 << ({1'b0, s} + {2'b00, il});
   endfunction
   // queue the pixels one word should produce, lowest bits first
   task automatic expect_word(input logic [23:0] w);
      int n;
      logic [7:0] idx;
      n = fc ? 8 : (1 << depth);
      if (fc) exp_q.push_back({pal_m[w[23:16]].red, pal_m[w[15:8]].green, pal_m[w[7:0]].blue});
      else for (int p = 0; p < 8 / n; p++) begin
         idx = (w[7:0] >> (p * n)) & ((9'h001 << n) - 9'h001);
         exp_q.push_back(pal_m[idx]);
      end
   endtask
   task automatic send_word(input logic [23:0] w);
      int t;
      expect_word(w);
      word = w;
      slow = 1'($random(seed));
      send = 1'b1;
      cycles(1);
      send = 1'b0;
      for (t = 0; t < 200 && busy !== 1'b0; t++) cycles(1);
      if (t == 200) check_val(24'h000001, 24'h000000);
   endtask
   task automatic drain();
      for (int t = 0; t < 400 && exp_q.size() != 0; t++) cycles(1);
      check_val(24'(exp_q.size()), 24'h000000);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      seed = 32'h9518;
      {num_errors, n_tests, cyc, n_pix} = '0;
      {en, fc, ilace, bdrv, lblank, ext_blank, pwe, fs, xr, send, slow} = '0;
      {depth, ssel, stall_mode, pwa, word, pwd} = '0;
      pix_ready = 1'b1;
      arst_n_in = 1'b0;
      cycles(20);
      check_val(24'(xstep), 24'h000100);
      check_val(24'(oe_n), 24'h000001);
      arst_n_in = 1'b1;
      cycles(2);
      // palette loaded with the generator stopped
      for (i = 0; i < 256; i++) begin
         pal_m[i] = vtp_pkg::vtp_rgb_s'(24'($random(seed)));
         {pwa, pwd, pwe} = {8'(i), pal_m[i], 1'b1};
         cycles(1);
      end
      pwe = 1'b0;
      $display("test palette done");
      // every depth, stop-reprogram-restart each time
      for (k = 0; k < 5; k++) begin
         en = 1'b0;
         cycles(2);
         fc = (k == 4);
         depth = 2'(3 - k);
         stall_mode = 2'(k & 1);
         en = 1'b1;
         n_pix = 0;
         send_word(24'hFFFFE4);
         send_word(24'h000000);
         for (i = 0; i < 10; i++) send_word(24'($random(seed)));
         drain();
         // pixels received over the twelve words must be twelve times the pixels per byte
         if (k < 4) check_val(24'(n_pix * 512 / 12), 24'(4096 >> depth));
         $display("test depth %0d done", k);
      end
      // hold the receiver off so the two-entry buffer fills
      stall_mode = 2'h2;
      send_word(24'h0000A5);
      send_word(24'h00005A);
      cycles(10);
      check_val(24'(pvalid), 24'h000001);
      stall_mode = 2'h0;
      drain();
      $display("test stall done");
      // identity palette gives straight pass-through in full colour
      en = 1'b0;
      cycles(2);
      for (i = 0; i < 256; i++) begin
         pal_m[i] = {3{8'(i)}};
         {pwa, pwd, pwe} = {8'(i), pal_m[i], 1'b1};
         cycles(1);
      end
      pwe = 1'b0;
      en = 1'b1;
      for (i = 0; i < 4; i++) send_word(24'($random(seed)));
      drain();
      $display("test identity done");
      // all eight step codes, then address stepping
      for (i = 0; i < 8; i++) begin
         {ilace, ssel} = 3'(i);
         cycles(2);
         check_val(24'(xstep), exp_step(ilace, ssel));
         {fs, xr} = 2'b11;
         cycles(1);
         {fs, xr} = 2'b00;
         check_val(xaddr, 24'h000000);
         k = 1 + ($unsigned($random(seed)) % 5);
         xr = 1'b1;
         cycles(k);
         xr = 1'b0;
         check_val(xaddr, 24'(exp_step(ilace, ssel) * k));
      end
      $display("test step done");
      // blank pin driven, then read from outside
      {bdrv, lblank} = 2'b11;
      cycles(2);
      check_val({oe_n, bpin_out, bact}, 24'h000003);
      // input mode: own blank is ignored, the far device's level is followed
      {bdrv, lblank, ext_blank} = 3'b010;
      cycles(8);
      check_val({oe_n, bact}, 24'h000002);
      ext_blank = 1'b1;
      cycles(8);
      check_val({oe_n, bact}, 24'h000003);
      ext_blank = 1'b0;
      cycles(8);
      check_val({oe_n, bact}, 24'h000002);
      $display("test blank done");
      give_verdict();
   end
endmodule
